// >>> fcaps_pkg.sv
// Constants for the pixel-clock frequency counter and remote capability registers.
// Assumes a single 125 MHz reference clock and an 8-bit register access port.
package fcaps_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_FREQ_COUNT = 8'h1F; // Frequency count register.
  localparam logic [7:0] ADDR_CAPS_FIRST = 8'h20; // First capability register.
  localparam logic [7:0] ADDR_CAPS_SECOND = 8'h21; // Second capability register, all reserved.

  // ----------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] FREQ_COUNT_RESET = 8'h00; // Count value after reset.
  localparam logic [7:0] CAPS_RESET = 8'h00; // Capability value after reset.
  localparam logic [7:0] COUNT_MAX = 8'hFF; // Saturation value of the edge count.
  localparam int CAP_FREEZE_BIT = 7; // Stops automatic capability loading.
  localparam int CAP_FREQ_TRAIN_BIT = 5; // Frequency training request.
  localparam int CAP_EQ_TRAIN_BIT = 4; // Equalization training request.
  localparam int CAP_DUAL_LINK_BIT = 3; // Remote side supports dual link.
  localparam int CAP_DUAL_CHAN_BIT = 2; // Zero primary, one secondary channel.
  localparam int CAP_WIDE_VIDEO_BIT = 1; // Wide video together with HD audio.
  localparam int CAP_FWD_GPIO_BIT = 0; // GPIO carried in forward frame.
  localparam logic [7:0] CAP_LOAD_MASK = 8'h3F; // Bits that the control channel loads.
  localparam logic [7:0] CAP_SW_MASK = 8'hBF; // Bits that software may write.

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int OSC_PERIOD_NS = 40; // Oscillator period, one interval unit.
  localparam int CLK_PERIOD_NS = 8; // Reference clock period.
  localparam int UNIT_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [2:0] UNIT_LAST = 3'(UNIT_CYCLES - 1); // Last prescaler state of a unit.

endpackage

// >>> fcaps_edge_sync.sv
// Two-flop synchroniser with a rising-edge pulse for an asynchronous pin.
// Assumes the pin toggles slower than half the sampling clock.
`timescale 1ns/1ps
module fcaps_edge_sync (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Pin and detected edge
  input wire logic pin_async,
  output logic rise_pulse
);

  logic meta_q; // First stage, read only by the second stage.
  logic sync_q; // Second stage, safe to use.
  logic last_q; // Previous synchronised level for edge detection.

  // ----------------------------------------------------------------
  // Synchroniser chain
  // ----------------------------------------------------------------
  // The edge detector looks at the second and third stages only.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      last_q <= 1'b0;
    end else if (ce) begin
      meta_q <= pin_async;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end

  assign rise_pulse = sync_q & ~last_q; // One cycle high per rising edge.

endmodule

// >>> fcaps_regs.sv
// Pixel-clock frequency counter and remote capability registers.
// Assumes the register port is driven by the serial control bus slave on ref_clk,
// and the capability load strobe comes from the control channel on the same clock.
`timescale 1ns/1ps
module fcaps_regs (
  // Clock, reset and enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // Register access port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Pixel clock pin, sampled asynchronously
  input wire logic pixel_clk_pin,
  // Control channel capability load
  input wire logic rx_lock,
  input wire logic cap_load,
  input wire logic [7:0] cap_load_data,
  // Status and capability outputs
  output logic meas_busy,
  output logic freq_training_request,
  output logic eq_training_request,
  output logic dual_link_capable,
  output logic dual_channel_secondary,
  output logic wide_video_with_hd_audio,
  output logic forward_gpio_capable
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic pix_edge; // One-cycle pulse per synchronised pixel clock rising edge.
  logic freq_wr; // Write to the frequency count register.
  logic caps_wr; // Write to the first capability register.
  logic freq_rd; // Read of the frequency count register.
  logic caps_rd; // Read of the first capability register.
  logic unit_end; // Last reference cycle of one oscillator unit.
  logic count_inc; // Count one more edge this cycle.
  logic cap_auto; // Control channel update accepted this cycle.
  logic [7:0] rdata_d; // Selected read data.
  logic [7:0] count_q; // Edge count, result of the last interval.
  logic [7:0] units_q; // Oscillator units left in the interval.
  logic [2:0] presc_q; // Reference cycles within the current unit.
  logic busy_q; // Interval in progress.
  logic [7:0] caps_q; // First capability register.
  logic [7:0] rdata_q; // Registered read data.

  // ----------------------------------------------------------------
  // Pixel clock edge detection
  // ----------------------------------------------------------------
  // Edges faster than half of ref_clk are undercounted; the result is a rough estimate only.
  fcaps_edge_sync u_pix_sync (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .ce(ce),
    .pin_async(pixel_clk_pin),
    .rise_pulse(pix_edge)
  );

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  assign freq_wr = reg_wr & (reg_addr == fcaps_pkg::ADDR_FREQ_COUNT);
  assign caps_wr = reg_wr & (reg_addr == fcaps_pkg::ADDR_CAPS_FIRST);
  assign freq_rd = reg_rd & (reg_addr == fcaps_pkg::ADDR_FREQ_COUNT);
  assign caps_rd = reg_rd & (reg_addr == fcaps_pkg::ADDR_CAPS_FIRST);
  // The second capability register is fully reserved and reads zero, as does any other address.
  assign rdata_d = freq_rd ? count_q : (caps_rd ? caps_q : 8'h00);

  // ----------------------------------------------------------------
  // Measurement timing
  // ----------------------------------------------------------------
  assign unit_end = busy_q & (presc_q == fcaps_pkg::UNIT_LAST);
  // Counting stops at the maximum instead of wrapping.
  assign count_inc = busy_q & pix_edge & (count_q != fcaps_pkg::COUNT_MAX);

  // A write restarts the measurement from zero; a zero interval counts nothing.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      busy_q <= 1'b0;
      units_q <= 8'h00;
      presc_q <= 3'h0;
    end else if (ce) begin
      if (freq_wr) begin
        busy_q <= (reg_wdata != 8'h00);
        units_q <= reg_wdata;
        presc_q <= 3'h0;
      end else if (unit_end) begin
        presc_q <= 3'h0;
        units_q <= units_q - 8'h01;
        busy_q <= (units_q != 8'h01);
      end else if (busy_q) begin
        presc_q <= presc_q + 3'h1;
      end
    end
  end

  // The count clears on each write and then holds once the interval ends.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      count_q <= fcaps_pkg::FREQ_COUNT_RESET;
    end else if (ce) begin
      if (freq_wr) begin
        count_q <= 8'h00;
      end else if (count_inc) begin
        count_q <= count_q + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Capability register
  // ----------------------------------------------------------------
  // Automatic loads need lock and no freeze; a software write in the same cycle wins,
  // since it may be the write that sets the freeze bit.
  assign cap_auto = cap_load & rx_lock & ~caps_q[fcaps_pkg::CAP_FREEZE_BIT];

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      caps_q <= fcaps_pkg::CAPS_RESET;
    end else if (ce) begin
      if (caps_wr) begin
        // Software must set freeze with its own values to keep them.
        caps_q <= reg_wdata & fcaps_pkg::CAP_SW_MASK;
      end else if (cap_auto) begin
        // The freeze bit itself belongs to software and is kept.
        caps_q <= (caps_q & ~fcaps_pkg::CAP_LOAD_MASK)
                  | (cap_load_data & fcaps_pkg::CAP_LOAD_MASK);
      end
    end
  end

  // ----------------------------------------------------------------
  // Read data and status
  // ----------------------------------------------------------------
  // Read data is valid the cycle after the read strobe and holds until the next read.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rdata_q <= 8'h00;
    end else if (ce && reg_rd) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign meas_busy = busy_q;
  // Capability outputs are the register bits themselves, so they come from flops.
  assign freq_training_request = caps_q[fcaps_pkg::CAP_FREQ_TRAIN_BIT];
  assign eq_training_request = caps_q[fcaps_pkg::CAP_EQ_TRAIN_BIT];
  assign dual_link_capable = caps_q[fcaps_pkg::CAP_DUAL_LINK_BIT];
  assign dual_channel_secondary = caps_q[fcaps_pkg::CAP_DUAL_CHAN_BIT];
  assign wide_video_with_hd_audio = caps_q[fcaps_pkg::CAP_WIDE_VIDEO_BIT];
  assign forward_gpio_capable = caps_q[fcaps_pkg::CAP_FWD_GPIO_BIT];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  property p_start;
    ce && freq_wr && (reg_wdata != 8'h00) |=> busy_q && (count_q == 8'h00);
  endproperty
  a_start: assert property (p_start) else $error("Write did not start a measurement.");

  property p_unit_len;
    (ce && freq_wr && (reg_wdata == 8'h02)) ##1 (ce && !freq_wr)[*8] ##1 (ce && !freq_wr)
      |=> busy_q ##1 (!busy_q || $past(freq_wr || !ce));
  endproperty
  a_unit_len: assert property (p_unit_len) else $error("Interval length is not ten cycles.");

  property p_read;
    ce && freq_rd |=> reg_rdata == $past(count_q);
  endproperty
  a_read: assert property (p_read) else $error("Frequency read did not return the count.");

  property p_saturate;
    ce && !freq_wr && (count_q == 8'hFF) |=> count_q == 8'hFF;
  endproperty
  a_saturate: assert property (p_saturate) else $error("Count left its maximum.");

  property p_increment;
    ce && !freq_wr && busy_q && pix_edge && (count_q != 8'hFF) |=> count_q == $past(count_q) + 8'h01;
  endproperty
  a_increment: assert property (p_increment) else $error("Edge was not counted.");

  property p_hold;
    ce && !freq_wr && !busy_q |=> $stable(count_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Result changed after the interval.");

  property p_freeze;
    ce && !caps_wr && caps_q[7] |=> $stable(caps_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("Frozen capabilities changed.");

  property p_load;
    ce && !caps_wr && cap_load && rx_lock && !caps_q[7]
      |=> caps_q[5:0] == $past(cap_load_data[5:0]) && !caps_q[7];
  endproperty
  a_load: assert property (p_load) else $error("Capabilities were not loaded.");

  property p_no_lock;
    ce && !caps_wr && !rx_lock |=> $stable(caps_q);
  endproperty
  a_no_lock: assert property (p_no_lock) else $error("Capabilities loaded without lock.");

  c_measure_done: cover property ($fell(busy_q) && (count_q != 8'h00));
  c_saturated: cover property (busy_q && (count_q == 8'hFF));
  c_auto_load: cover property (cap_auto && ce);
  c_frozen_block: cover property (cap_load && rx_lock && caps_q[7]);

endmodule

// >>> fcaps_remote_model.sv
// Behavioural far end of the control channel: lock level and capability pushes.
// Assumes the bench drives link_up, send and caps just after ref_clk edges.
`timescale 1ns/1ps
module fcaps_remote_model (
  // Clock
  input wire logic ref_clk,
  // Commands from the bench
  input wire logic link_up,
  input wire logic send,
  input wire logic [5:0] caps,
  // Channel towards the device
  output logic rx_lock,
  output logic cap_load,
  output logic [7:0] cap_load_data
);
  // Idle data toggles so a stale value is never mistaken for a fresh push.
  initial begin
    rx_lock = 1'b0;
    cap_load = 1'b0;
    cap_load_data = 8'h00;
  end
  // One push per send cycle; pushes while unlocked are sent on purpose.
  always @(posedge ref_clk) begin
    rx_lock <= link_up;
    cap_load <= send;
    if (send) begin
      cap_load_data <= {2'b00, caps};
    end else begin
      cap_load_data <= ~cap_load_data;
    end
  end
endmodule

// >>> freq_counter_and_des_caps_bench.sv
// Self-checking bench for the frequency counter and capability registers.
// Assumes ce is high except in one ce-gating scenario at the end; the remote model stands in for the channel.
`timescale 1ns/1ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failures++; \
  $display("BAD %0t got %h exp %h", $time, (a), (e)); end end
module freq_counter_and_des_caps_bench;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic ce = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic pix = 1'b0;
  logic link_up = 1'b0;
  logic send = 1'b0;
  logic [5:0] caps = 6'h00;
  logic [7:0] reg_rdata;
  logic rx_lock, cap_load, meas_busy;
  logic [7:0] cap_load_data;
  logic [5:0] caps_o;
  int failures = 0;
  int checked = 0;
  always #4 ref_clk = ~ref_clk;
  fcaps_remote_model far (.ref_clk(ref_clk), .link_up(link_up), .send(send), .caps(caps),
    .rx_lock(rx_lock), .cap_load(cap_load), .cap_load_data(cap_load_data));
  fcaps_regs DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(ce), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pixel_clk_pin(pix),
    .rx_lock(rx_lock), .cap_load(cap_load), .cap_load_data(cap_load_data),
    .meas_busy(meas_busy), .freq_training_request(caps_o[5]), .eq_training_request(caps_o[4]),
    .dual_link_capable(caps_o[3]), .dual_channel_secondary(caps_o[2]),
    .wide_video_with_hd_audio(caps_o[1]), .forward_gpio_capable(caps_o[0]));
  // Verdict and end of run, shared by the main flow and the wait limits.
  task automatic finish_test();
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // One-cycle write strobe.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // One-cycle read strobe; data is registered and checked one edge later.
  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    @(posedge ref_clk);
    #1;
    `CHK(reg_rdata, e)
  endtask
  // Push capabilities from the far end and let the load land.
  task automatic push(input logic [5:0] v);
    @(posedge ref_clk);
    send <= 1'b1;
    caps <= v;
    @(posedge ref_clk);
    send <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
  endtask
  // Measure with n units while sending k pixel rising edges well inside the window.
  task automatic meas(input logic [7:0] n, input int k, input logic [7:0] e);
    int cyc;
    cyc = 0;
    wr(8'h1F, n);
    #1;
    fork
      begin
        repeat (2) @(posedge ref_clk);
        repeat (2 * k) begin
          repeat (2) @(posedge ref_clk);
          pix <= ~pix;
        end
      end
      while (meas_busy === 1'b1 && cyc < 2000) begin
        @(posedge ref_clk);
        #1;
        cyc++;
      end
    join
    if (cyc >= 2000) begin
      failures++;
      finish_test();
    end
    `CHK(cyc, 5 * int'(n))
    rdc(fcaps_pkg::ADDR_FREQ_COUNT, e);
    repeat (20) @(posedge ref_clk);
    rdc(fcaps_pkg::ADDR_FREQ_COUNT, e);
  endtask
  initial begin
    repeat (2) @(posedge ref_clk);
    nrst <= 1'b1;
    rdc(fcaps_pkg::ADDR_FREQ_COUNT, fcaps_pkg::FREQ_COUNT_RESET);
    rdc(fcaps_pkg::ADDR_CAPS_FIRST, fcaps_pkg::CAPS_RESET);
    meas(8'h04, 3, 8'h03);
    // Two units give the ten-cycle window that the interval assertion watches.
    meas(8'h02, 1, 8'h01);
    meas(8'hFF, 300, fcaps_pkg::COUNT_MAX);
    wr(8'h1F, 8'h00);
    rdc(fcaps_pkg::ADDR_FREQ_COUNT, 8'h00);
    // A push while unlocked must not land.
    push(6'h3F);
    `CHK(caps_o, 6'h00)
    // Lock is raised on an edge like every other stimulus.
    @(posedge ref_clk);
    link_up <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      push(6'(1 << i));
      `CHK(caps_o, 6'(1 << i))
      rdc(fcaps_pkg::ADDR_CAPS_FIRST, 8'(1 << i));
    end
    wr(fcaps_pkg::ADDR_CAPS_FIRST, 8'h95);
    push(6'h2A);
    `CHK(caps_o, 6'h15)
    rdc(fcaps_pkg::ADDR_CAPS_FIRST, 8'h95);
    wr(fcaps_pkg::ADDR_CAPS_FIRST, 8'hFF);
    rdc(fcaps_pkg::ADDR_CAPS_FIRST, 8'hBF);
    wr(fcaps_pkg::ADDR_CAPS_FIRST, 8'h00);
    push(6'h2A);
    rdc(fcaps_pkg::ADDR_CAPS_FIRST, 8'h2A);
    wr(fcaps_pkg::ADDR_CAPS_SECOND, 8'hFF);
    wr(8'h40, 8'h12);
    rdc(fcaps_pkg::ADDR_CAPS_SECOND, 8'h00);
    rdc(8'h40, 8'h00);
    // With ce low neither a software write nor a locked push may change anything.
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(fcaps_pkg::ADDR_CAPS_FIRST, 8'h80);
    push(6'h15);
    `CHK(caps_o, 6'h2A)
    @(posedge ref_clk);
    ce <= 1'b1;
    rdc(fcaps_pkg::ADDR_CAPS_FIRST, 8'h2A);
    finish_test();
  end
endmodule
